// [src/event_counter.v]
// Dual input event counter core with diagnostics and self-test.
// ----------------------------------------
// Overview of operation
// ----------------------------------------
// Overview of operation
// - Inhibit mode: B high enables falling-A counts.
// - Up/down mode: falling A, B sets direction.
// - Add/subtract: A adds, B subtracts, no loss.
// - Add mode: both inputs add, no loss.
// - Quadrature, B low: A fall up, rise down.
// - Quadrature single edge: ignore A while B high.
// - Quadrature two edge: B high complements directions.
// - Quadrature x4 counts every edge of both, except when A and B change in the same cycle.
// - Overflow lights past six or nine digits.
// - Display overflow keeps count; accumulator may not.
// - Count (not settings) saved; reset clears it, so power-up restores zero.
// - Check value mismatch shows retained-data glyph.
// - Watchdog failure shows watchdog error glyph only while no check value mismatch is flagged.
// - Function six plus sign starts non-intrusive self-test.
// - Self-test shows the documented pattern sequence.
// - Patterns last half second; sign key advances.
// - After patterns keys drive outputs when unlocked.
// - Self-test exits after six seconds or lock.
// - Personality select loads mode defaults first.
// - Edge setting ignored while quadrature x4 active.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"
module event_counter #(
    parameter [35:0] PATTERN_CYCLES  = `PATTERN_NS / `CLK_NS,
    parameter [35:0] SELFTEST_CYCLES = `SELFTEST_NS / `CLK_NS,
    parameter [23:0] WDOG_CYCLES     = `WDOG_CYCLES
) (
    // Clock, reset and enable
    input  wire        CLK_SYS,
    input  wire        RSTN,
    input  wire        CLK_EN,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // Count inputs and lock pin
    input  wire        IN_A,
    input  wire        IN_B,
    input  wire        PROGRAMMING_LOCK_INPUT,
    // Indicators and outputs
    output reg         OVERFLOW_LED,
    output reg         MINUS_LED,
    output reg  [5:0]  DECIMAL_POINTS,
    output reg  [23:0] DISPLAY_DIGITS,
    output reg         TEST_ACTIVE,
    output reg         OUT1,
    output reg         OUT2
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    reg [2:0] sync_a;
    reg [2:0] sync_b;
    reg [2:0] sync_l;
    reg       a_st;
    reg       b_st;
    reg       lock_st;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_l <= 3'h0;
            a_st <= 1'b0;
            b_st <= 1'b0;
            lock_st <= 1'b0;
        end else if (CLK_EN) begin
            sync_a <= {sync_a[1:0], IN_A};
            sync_b <= {sync_b[1:0], IN_B};
            sync_l <= {sync_l[1:0], PROGRAMMING_LOCK_INPUT};
            if (sync_a[2] == sync_a[1])
                a_st <= sync_a[1];
            if (sync_b[2] == sync_b[1])
                b_st <= sync_b[1];
            if (sync_l[2] == sync_l[1])
                lock_st <= sync_l[1];
        end
    end
    reg a_prev;
    reg b_prev;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else if (CLK_EN) begin
            a_prev <= a_st;
            b_prev <= b_st;
        end
    end
    wire a_rise = a_st & ~a_prev;
    wire a_fall = ~a_st & a_prev;
    wire b_rise = b_st & ~b_prev;
    wire b_fall = ~b_st & b_prev;
    wire a_edge = a_rise | a_fall;
    wire b_edge = b_rise | b_fall;

    // ----------------------------------------
    // Mode registers
    // ----------------------------------------
    reg [2:0] resp_mode;
    reg       edge_mode;
    reg       personality;

    // ----------------------------------------
    // Count step decoding
    // ----------------------------------------
    reg       pend_a;
    reg       pend_b;
    reg       step_en;
    reg       step_dn;
    reg       next_pend_a;
    reg       next_pend_b;
    wire      a_any = (edge_mode == `EDGE_TWO) ? a_edge : a_fall;
    always @* begin
        step_en = 1'b0;
        step_dn = 1'b0;
        next_pend_a = pend_a;
        next_pend_b = pend_b;
        case (resp_mode)
            `RESP_INHIBIT: begin
                step_en = a_any & b_st;
            end
            `RESP_UPDOWN: begin
                step_en = a_any;
                step_dn = ~b_st;
            end
            `RESP_AC_ADDSUB, `RESP_AC_ADD: begin
                // Pulses queue one deep per input, served A first.
                next_pend_a = pend_a | a_any;
                next_pend_b = pend_b | ((edge_mode == `EDGE_TWO) ?
                              b_edge : b_fall);
                if (next_pend_a) begin
                    step_en = 1'b1;
                    next_pend_a = 1'b0;
                end else if (next_pend_b) begin
                    step_en = 1'b1;
                    step_dn = (resp_mode == `RESP_AC_ADDSUB);
                    next_pend_b = 1'b0;
                end
            end
            `RESP_QUAD: begin
                if (!b_st) begin
                    step_en = a_edge;
                    step_dn = a_rise;
                end else if (edge_mode == `EDGE_TWO) begin
                    step_en = a_edge;
                    step_dn = a_fall;
                end
            end
            `RESP_QUAD_X4: begin
                step_en = a_edge | b_edge;
                // A leading B counts up on every edge.
                step_dn = a_edge ? (a_st == b_st) : (a_st != b_st);
                if (a_edge && b_edge)
                    step_en = 1'b0;
            end
            default: begin
                step_en = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Accumulator and overflow
    // ----------------------------------------
    reg  [39:0] count;
    reg  [39:0] next_count;
    reg         acc_ovf;
    wire        cnt_neg = count[39];
    wire [39:0] cnt_mag = cnt_neg ? (40'h0 - count) : count;
    wire        clear_cmd;
    wire        restore_cmd;
    wire [39:0] restore_val;
    always @* begin
        next_count = count;
        if (step_en)
            next_count = step_dn ? count - 40'h1 : count + 40'h1;
    end
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            count <= 40'h0;
            acc_ovf <= 1'b0;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
        end else if (CLK_EN) begin
            pend_a <= next_pend_a;
            pend_b <= next_pend_b;
            if (clear_cmd) begin
                count <= 40'h0;
                acc_ovf <= 1'b0;
            end else if (restore_cmd) begin
                count <= restore_val;
            end else begin
                count <= next_count;
                if (step_en && cnt_mag == `ACC_LIMIT &&
                    step_dn == cnt_neg)
                    acc_ovf <= 1'b1;
            end
        end
    end
    wire disp_ovf = (cnt_mag > `DISP_LIMIT);

    // ----------------------------------------
    // Retention, check value and watchdog
    // ----------------------------------------
    reg  [31:0] save_data;
    reg  [31:0] save_check;
    reg         parity_err;
    reg         wdog_err;
    reg  [23:0] wdog_cnt;
    reg  [1:0]  boot;
    function [31:0] check_of;
        input [31:0] d;
        begin
            check_of = {d[15:0], d[31:16]} ^ 32'h5A5A_A5A5;
        end
    endfunction
    assign restore_cmd = (boot == 2'h1);
    assign restore_val = {{8{save_data[31]}}, save_data};

    // ----------------------------------------
    // Self-test sequencer
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_PAT  = 2'h1;
    localparam ST_OUT  = 2'h2;
    reg [1:0]  st_state;
    reg [4:0]  st_step;
    reg [35:0] pat_cnt;
    reg [35:0] tot_cnt;
    reg        key_start;
    reg        key_sign;
    reg        key_one;
    reg        key_two;
    wire       pat_done = (pat_cnt >= PATTERN_CYCLES - 36'h1) | key_sign;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_state <= ST_IDLE;
            st_step <= 5'h0;
            pat_cnt <= 36'h0;
            tot_cnt <= 36'h0;
        end else if (CLK_EN) begin
            case (st_state)
                ST_IDLE: begin
                    if (key_start) begin
                        st_state <= ST_PAT;
                        st_step <= 5'h0;
                        pat_cnt <= 36'h0;
                        tot_cnt <= 36'h0;
                    end
                end
                ST_PAT, ST_OUT: begin
                    tot_cnt <= tot_cnt + 36'h1;
                    if (!lock_st ||
                        tot_cnt >= SELFTEST_CYCLES - 36'h1) begin
                        st_state <= ST_IDLE;
                    end else if (st_state == ST_PAT) begin
                        pat_cnt <= pat_done ? 36'h0 : pat_cnt + 36'h1;
                        if (pat_done) begin
                            if (st_step == 5'd19)
                                st_state <= ST_OUT;
                            else
                                st_step <= st_step + 5'h1;
                        end
                    end
                end
                default: begin
                    st_state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    wire wr = PSEL & PENABLE & PWRITE & ~PREADY;
    wire rd = PSEL & PENABLE & ~PWRITE & ~PREADY;
    reg  clear_req;
    reg  kick;
    assign clear_cmd = clear_req;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            resp_mode <= `RESP_INHIBIT;
            edge_mode <= `EDGE_SINGLE;
            personality <= 1'b0;
            clear_req <= 1'b0;
            kick <= 1'b0;
            key_start <= 1'b0;
            key_sign <= 1'b0;
            key_one <= 1'b0;
            key_two <= 1'b0;
            save_data <= 32'h0;
            save_check <= 32'h0;
            parity_err <= 1'b0;
            wdog_err <= 1'b0;
            wdog_cnt <= 24'h0;
            boot <= 2'h0;
        end else if (CLK_EN) begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= 1'b0;
            clear_req <= 1'b0;
            kick <= 1'b0;
            key_start <= 1'b0;
            key_sign <= 1'b0;
            if (boot == 2'h0) begin
                boot <= 2'h1;
            end else if (boot == 2'h1) begin
                boot <= 2'h2;
                if (check_of(save_data) != save_check)
                    parity_err <= 1'b1;
            end
            wdog_cnt <= kick ? 24'h0 : wdog_cnt + 24'h1;
            if (wdog_cnt >= WDOG_CYCLES - 24'h1)
                wdog_err <= 1'b1;
            if (wr) begin
                case (PADDR)
                    `ADDR_CONTROL: begin
                        clear_req <= PWDATA[`CTRL_CLEAR];
                        kick <= PWDATA[`CTRL_WDOG_KICK];
                        if (PWDATA[`CTRL_SAVE]) begin
                            save_data <= count[31:0];
                            save_check <= check_of(count[31:0]);
                        end
                    end
                    `ADDR_MODE: begin
                        if (PWDATA[`MODE_PERS_BIT]) begin
                            personality <= 1'b1;
                            resp_mode <= `RESP_INHIBIT;
                            edge_mode <= `EDGE_SINGLE;
                        end else if (personality) begin
                            resp_mode <= PWDATA[`MODE_RESP_LSB+2:
                                                `MODE_RESP_LSB];
                            if (resp_mode != `RESP_QUAD_X4)
                                edge_mode <= PWDATA[`MODE_EDGE_BIT];
                        end
                    end
                    `ADDR_SAVE_DATA: save_data <= PWDATA;
                    `ADDR_SAVE_CHECK: save_check <= PWDATA;
                    `ADDR_KEYS: begin
                        key_start <= PWDATA[`KEY_FUNC6_SIGN];
                        key_sign <= PWDATA[`KEY_SIGN] &
                                    (st_state == ST_PAT);
                        key_one <= PWDATA[`KEY_ONE];
                        key_two <= PWDATA[`KEY_TWO];
                    end
                    default: PSLVERR <= 1'b1;
                endcase
            end
            if (rd) begin
                case (PADDR)
                    `ADDR_MODE: PRDATA <= {23'h0, personality, 3'h0,
                                           edge_mode, 1'b0, resp_mode};
                    `ADDR_STATUS: PRDATA <= {27'h0, st_state, acc_ovf,
                                             wdog_err, parity_err};
                    `ADDR_COUNT: PRDATA <= count[31:0];
                    `ADDR_SAVE_DATA: PRDATA <= save_data;
                    `ADDR_SAVE_CHECK: PRDATA <= save_check;
                    `ADDR_DISPLAY: PRDATA <= {8'h0, DISPLAY_DIGITS};
                    `ADDR_CONTROL, `ADDR_KEYS: PRDATA <= 32'h0;
                    default: begin
                        PRDATA <= 32'h0;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Display and outputs
    // ----------------------------------------
    // Low 24 bits of magnitude shown as hex nibbles; BCD left to firmware.
    reg [23:0] next_digits;
    reg [3:0]  lo;
    always @* begin
        lo = st_step[3:0] - 4'hB;
        next_digits = cnt_mag[23:0];
        if (parity_err)
            next_digits = {`GLYPH_PARITY, cnt_mag[19:0]};
        else if (wdog_err)
            next_digits = {`GLYPH_WDOG, cnt_mag[19:0]};
        if (st_state != ST_IDLE) begin
            if (st_step == 5'h0)
                next_digits = 24'h0;
            else if (st_step <= 5'd10)
                next_digits = {6{4'd10 - st_step[3:0]}};
            else
                next_digits = {3{(lo + 4'h1) & 4'hE, lo | 4'h1}};
        end
    end
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            OVERFLOW_LED <= 1'b0;
            MINUS_LED <= 1'b0;
            DECIMAL_POINTS <= 6'h0;
            DISPLAY_DIGITS <= 24'h0;
            TEST_ACTIVE <= 1'b0;
            OUT1 <= 1'b0;
            OUT2 <= 1'b0;
        end else if (CLK_EN) begin
            DISPLAY_DIGITS <= next_digits;
            TEST_ACTIVE <= (st_state != ST_IDLE);
            DECIMAL_POINTS <= (st_state != ST_IDLE && st_step == 5'h0) ?
                              6'h3F : 6'h0;
            if (st_state == ST_IDLE) begin
                OVERFLOW_LED <= disp_ovf | acc_ovf;
                MINUS_LED <= cnt_neg;
            end else begin
                OVERFLOW_LED <= (st_step <= 5'd10);
                MINUS_LED <= (st_step > 5'd10);
            end
            OUT1 <= (st_state == ST_OUT) & lock_st & key_one;
            OUT2 <= (st_state == ST_OUT) & lock_st & key_two;
        end
    end
endmodule // event_counter
`default_nettype wire

// [src/event_counter_regs.vh]
// Constants for the dual input event counter.
`ifndef EVENT_COUNTER_REGS_VH
`define EVENT_COUNTER_REGS_VH
`define ADDR_CONTROL    12'h000
`define ADDR_MODE       12'h004
`define ADDR_STATUS     12'h008
`define ADDR_COUNT      12'h00C
`define ADDR_SAVE_DATA  12'h010
`define ADDR_SAVE_CHECK 12'h014
`define ADDR_KEYS       12'h018
`define ADDR_DISPLAY    12'h01C
`define CTRL_CLEAR      0
`define CTRL_SAVE       1
`define CTRL_WDOG_KICK  2
`define MODE_RESP_LSB   0
`define MODE_EDGE_BIT   4
`define MODE_PERS_BIT   8
`define KEY_FUNC6_SIGN  0
`define KEY_SIGN        1
`define KEY_ONE         2
`define KEY_TWO         3
`define RESP_INHIBIT    3'h1
`define RESP_UPDOWN     3'h2
`define RESP_AC_ADDSUB  3'h3
`define RESP_AC_ADD     3'h4
`define RESP_QUAD       3'h5
`define RESP_QUAD_X4    3'h6
`define EDGE_SINGLE     1'b0
`define EDGE_TWO        1'b1
`define DISP_LIMIT      40'h00000F423F
`define ACC_LIMIT       40'h003B9AC9FF
`define GLYPH_PARITY    4'hA
`define GLYPH_WDOG      4'hB
`define PATTERN_NS      500000000
`define SELFTEST_NS     36'h165A0BC00
`define CLK_NS          100
`define WDOG_CYCLES     24'h0F4240
`endif

// [sim/event_counter_monitor.sv]
// Port level assertion checker for the event counter.
`timescale 1ns/1ps
`default_nettype none
module event_counter_monitor #(
    parameter [35:0] SELFTEST_CYCLES = 36'h258
) (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic        CLK_EN,
    // Bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Panel
    input wire logic        PROGRAMMING_LOCK_INPUT,
    input wire logic        OVERFLOW_LED,
    input wire logic        MINUS_LED,
    input wire logic [5:0]  DECIMAL_POINTS,
    input wire logic        TEST_ACTIVE,
    input wire logic        OUT1,
    input wire logic        OUT2
);
    // Counting the run length avoids a huge repetition in a property.
    logic [35:0] test_len;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN)
            test_len <= 36'h0;
        else
            test_len <= TEST_ACTIVE ? test_len + 36'h1 : 36'h0;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    chk_ready_wait: assert property (PSEL && PENABLE && !PREADY && CLK_EN
        |=> PREADY) else $error("ready missing after access");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer malformed");
    chk_test_entry: assert property (
        $rose(TEST_ACTIVE) |-> ##[0:2]
        (DECIMAL_POINTS == 6'h3F && OVERFLOW_LED))
        else $error("self test did not open with points");
    chk_minus_phase: assert property (
        TEST_ACTIVE && $rose(MINUS_LED) |-> !OVERFLOW_LED)
        else $error("minus lit with overflow");
    chk_out_gate: assert property ((OUT1 || OUT2) |-> TEST_ACTIVE)
        else $error("output driven outside self test");
    chk_lock_outs: assert property (
        !PROGRAMMING_LOCK_INPUT [*8] |-> !OUT1 && !OUT2)
        else $error("output driven while locked");
    chk_lock_exit: assert property (
        TEST_ACTIVE && !PROGRAMMING_LOCK_INPUT |-> ##[1:8] !TEST_ACTIVE)
        else $error("self test kept running when locked");
    chk_test_bound: assert property (
        test_len <= SELFTEST_CYCLES + 36'h4)
        else $error("self test overran its time");
    cover property ($rose(TEST_ACTIVE));
    cover property (PSLVERR);
    cover property (OUT1);
    cover property ($fell(TEST_ACTIVE) && !PROGRAMMING_LOCK_INPUT);
endmodule // event_counter_monitor
bind event_counter event_counter_monitor #(
    .SELFTEST_CYCLES(SELFTEST_CYCLES)) i_mon (.*);
`default_nettype wire

// [sim/sensor_source.sv]
// Model of the contacts or encoder feeding the two count lines.
`timescale 1ns/1ps
`default_nettype none
module sensor_source (
    // Clock
    input  wire logic clk_sys,
    // Count lines
    output var  logic in_a,
    output var  logic in_b
);
    // Lines idle high, as a pulled-up contact does.
    initial begin
        in_a = 1'b1;
        in_b = 1'b1;
    end
    // Each level is held well past the input filter.
    task automatic move(input logic a, input logic b, input logic slow);
        @(posedge clk_sys);
        in_a <= a;
        in_b <= b;
        repeat (slow ? 24 : 8) @(posedge clk_sys);
    endtask
endmodule // sensor_source
`default_nettype wire

// [sim/dual_input_event_counter_bench.sv]
// Self-checking bench for the dual input event counter.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"
module dual_input_event_counter_bench;
    localparam [35:0] PAT = 36'h14;
    localparam [35:0] TST = 36'h258;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic        lock = 1'b1;
    logic        err;
    logic        la = 1'b1;
    logic        lb = 1'b1;
    logic [31:0] rd, cnt, r;
    logic [23:0] ref_d;
    wire  [31:0] prd;
    wire  [23:0] dig;
    wire  [5:0]  dps;
    wire         prdy, perr, ina, inb, ovf, mns, tact, o1, o2;
    integer      mismatches = 0;
    integer      checks = 0;
    integer      seed = 86;
    integer      m, k, t, tc;
    time         t0;
    event_counter #(.PATTERN_CYCLES(PAT), .SELFTEST_CYCLES(TST),
                    .WDOG_CYCLES(24'h32)) i_dut (
        .CLK_SYS(clk), .RSTN(rstn), .CLK_EN(1'b1),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(addr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .IN_A(ina), .IN_B(inb), .PROGRAMMING_LOCK_INPUT(lock),
        .OVERFLOW_LED(ovf), .MINUS_LED(mns), .DECIMAL_POINTS(dps),
        .DISPLAY_DIGITS(dig), .TEST_ACTIVE(tact), .OUT1(o1), .OUT2(o2));
    sensor_source i_src (.clk_sys(clk), .in_a(ina), .in_b(inb));
    initial forever #50 clk = ~clk;
    // ----------------------------------------
    // Tasks and expectations
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [39:0] seen,
                         input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        integer n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        rd = prd;
        err = perr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 20) begin
            check("pready", prdy, 1'b1);
            end_of_test();
        end
    endtask
    task automatic wait_fall(input integer lim);
        integer n;
        n = 0;
        while (tact !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n == lim) begin
            check("test exit", tact, 1'b0);
            end_of_test();
        end
    endtask
    task automatic start_test;
        apb(1'b1, `ADDR_KEYS, 32'h1);
        apb(1'b1, `ADDR_KEYS, 32'h0);
        check("test start", tact, 1'b1);
        t0 = $time;
        repeat (3) @(posedge clk);
    endtask
    function automatic integer delta(input integer md, input logic two,
                                     input logic pa, pb, a, b);
        logic fa, fb;
        fa = pa & ~a;
        fb = pb & ~b;
        case (md)
            1: return (fa & b) ? 1 : 0;
            2: return fa ? (b ? 1 : -1) : 0;
            3: return (fa ? 1 : 0) - (fb ? 1 : 0);
            4: return (fa ? 1 : 0) + (fb ? 1 : 0);
            5: return (pa == a) ? 0 : !b ? (fa ? 1 : -1) :
                      two ? (fa ? -1 : 1) : 0;
            default: return (pa != a) ? ((a != b) ? 1 : -1) :
                            (pb != b) ? ((a == b) ? 1 : -1) : 0;
        endcase
    endfunction
    function automatic logic [23:0] pat(input integer n);
        logic [3:0] h, l;
        if (n < 10)
            return {6{4'(9 - n)}};
        h = 4'(2 * ((n - 9) / 2));
        l = 4'(2 * ((n - 10) / 2) + 1);
        return {3{h, l}};
    endfunction
    task automatic step(input integer md, input logic two, a, b);
        cnt = cnt + delta(md, two, la, lb, a, b);
        i_src.move(a, b, $random(seed) % 2 == 0);
        la = a;
        lb = b;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("parity flag", rd[0], 1'b1);
        check("left glyph", dig[23:20], `GLYPH_PARITY);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, `ADDR_CONTROL, 32'h4);
            repeat (30) @(posedge clk);
        end
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("wdog kept", rd[1], 1'b0);
        repeat (60) @(posedge clk);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("wdog flag", rd[1], 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", {err, rd}, 33'h100000000);
        apb(1'b0, `ADDR_MODE, 32'h0);
        r = rd;
        apb(1'b1, `ADDR_MODE, 32'h2);
        apb(1'b0, `ADDR_MODE, 32'h0);
        check("mode locked", rd, r);
        apb(1'b1, `ADDR_MODE, 32'h100);
        apb(1'b0, `ADDR_MODE, 32'h0);
        check("mode defaults", rd[4:0], 5'h01);
        $display("test diagnostics done");
        for (k = 0; k < 8; k++) begin
            m = (k < 5) ? k + 1 : (k < 6 ? 5 : 6);
            t = (k == 5 || k == 7);
            apb(1'b1, `ADDR_MODE, {27'h0, t[0], 1'b0, m[2:0]});
            apb(1'b0, `ADDR_MODE, 32'h0);
            check("edge bit", rd[4], t[0] & (m != 6));
            apb(1'b1, `ADDR_CONTROL, 32'h1);
            cnt = 32'h0;
            repeat (24) begin
                r = $random(seed);
                if (m > 2 && m < 5 && r[2:1] == 2'h0)
                    step(m, t[0], ~la, ~lb);
                else if (r[0])
                    step(m, t[0], ~la, lb);
                else
                    step(m, t[0], la, ~lb);
            end
            repeat (10) @(posedge clk);
            apb(1'b0, `ADDR_COUNT, 32'h0);
            check("count", rd, cnt);
            $display("test mode %0d edge %0d done", m, t);
        end
        apb(1'b1, `ADDR_CONTROL, 32'h2);
        apb(1'b0, `ADDR_SAVE_DATA, 32'h0);
        check("saved count", rd, cnt);
        apb(1'b0, `ADDR_SAVE_CHECK, 32'h0);
        check("check word", rd, {cnt[15:0], cnt[31:16]} ^ 32'h5A5AA5A5);
        start_test();
        check("dp pattern", {dps, ovf}, 7'h7F);
        ref_d = dig;
        k = 0;
        t = 0;
        tc = 0;
        while (tact === 1'b1 && k < 19 && t < 700) begin
            @(posedge clk);
            t++;
            if (dig !== ref_d) begin
                check("pattern", dig, pat(k));
                if (k == 2)
                    check("hold", t - tc > PAT - 2 && t - tc < PAT + 2, 1'b1);
                if (k == 10)
                    check("minus", {mns, ovf}, 2'h2);
                ref_d = dig;
                tc = t;
                k++;
            end
        end
        check("patterns seen", k, 19);
        repeat (24) @(posedge clk);
        apb(1'b1, `ADDR_KEYS, 32'h4);
        repeat (6) @(posedge clk);
        check("key one", {o1, o2}, 2'h2);
        apb(1'b1, `ADDR_KEYS, 32'h8);
        repeat (6) @(posedge clk);
        check("key two", {o1, o2}, 2'h1);
        apb(1'b1, `ADDR_KEYS, 32'h0);
        wait_fall(800);
        t = ($time - t0) / 100;
        check("test length", t > TST - 8 && t < TST + 8, 1'b1);
        $display("test self test timing done");
        start_test();
        apb(1'b1, `ADDR_KEYS, 32'h2);
        apb(1'b1, `ADDR_KEYS, 32'h0);
        check("sign advance", dig, 24'h999999);
        for (k = 0; k < 4; k++)
            step(6, 1'b0, k[0] ? la : ~la, k[0] ? ~lb : lb);
        lock <= 1'b0;
        wait_fall(12);
        check("lock exit", tact, 1'b0);
        lock <= 1'b1;
        repeat (10) @(posedge clk);
        apb(1'b0, `ADDR_COUNT, 32'h0);
        check("count in test", rd, cnt);
        $display("test self test lock done");
        end_of_test();
    end
endmodule // dual_input_event_counter_bench
`default_nettype wire
